// *** hw/flash_rst_pkg.sv ***
package flash_rst_pkg;

    typedef logic [1:0] bus_width_type;

    localparam logic [7:0] OP_TERMINATE = 8'hF0;
    localparam logic [7:0] TERMINATE_CONFIRM = 8'hD0;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;

    localparam logic [3:0] HW_PATTERN = 4'h5;
    localparam logic [2:0] HW_PATTERN_LEN = 3'h4;

    localparam bus_width_type BUS_SPI = 2'h0;
    localparam bus_width_type BUS_QUAD = 2'h1;
    localparam bus_width_type BUS_OCTAL = 2'h2;

    localparam bus_width_type BUS_WIDTH_RESET = BUS_SPI;
    localparam logic DTR_RESET = 1'h0;
    localparam logic TERMINATE_ENABLE_BIT_RESET = 1'h0;

    localparam int CORE_CLK_MHZ = 100;
    localparam int TERMINATE_LATENCY_NS = 1000;
    localparam int SOFT_RESET_RECOVERY_NS = 28000;
    // Least time rounds up, longest time rounds down
    localparam int TERMINATE_LATENCY_CYC =
        (TERMINATE_LATENCY_NS * CORE_CLK_MHZ) / 1000;
    localparam int SOFT_RESET_RECOVERY_CYC =
        (SOFT_RESET_RECOVERY_NS * CORE_CLK_MHZ + 999) / 1000;

    localparam logic [5:0] BIT_COUNT_MAX = 6'h3F;
    localparam logic [5:0] CAPTURE_BITS = 6'h10;

endpackage

// *** hw/flash_terminate_and_reset_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Confirmed terminate aborts program or erase, write-enable latch not needed.
// - Terminate is ignored while the terminate-enable bit is clear.
// - Confirmation byte follows the opcode directly; later bytes are ignored.
// - Abort issues at chip-select release, well inside the terminate latency.
// - Terminate keeps config and enable bit, clears write latch unless sequential.
// - Terminate needs both bytes complete and release on a byte boundary.
// - Reset-enable then reset performs a soft reset in every bus mode.
// - Any other instruction after reset-enable disarms the pair.
// - Soft reset aborts operations and defaults volatile status and protection.
// - Instructions are refused during the soft reset recovery interval.
// - Soft reset returns the interface to single-bit SPI.
// - Serial clock activity during the pattern aborts detection.
// - Four chip-select rising edges reading 0,1,0,1 signal a reset.
// - No output drive while chip select is low before a clock edge.
// - Serial input sampled per chip-select rise; reset after the fourth.
// - Pattern in deep sleep invalidates buffer; error flag kept after auto entry.
// - Pattern outside deep sleep keeps buffer and resets volatile status.
// - Pattern reset returns the interface to single-bit SPI.
// - Pattern reset also wakes the device from ultra-deep power-down.
// - Auto enable enters deep sleep after program or erase, then clears.
module flash_terminate_and_reset_control
    import flash_rst_pkg::*;
#(
    parameter int RECOVERY_CYCLES = SOFT_RESET_RECOVERY_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [7:0] i_io,
    input wire logic i_status2_write,
    input wire logic i_status2_terminate_enable,
    input wire logic i_sequential_programming,
    input wire logic i_mode_load,
    input wire logic [1:0] i_mode_width,
    input wire logic i_mode_dtr,
    input wire logic i_auto_deep_sleep_enable_bit,
    input wire logic i_program_erase_done,
    input wire logic i_ultra_deep_power_down_mode_enter,
    input wire logic i_ultra_deep_power_down_mode_exit,
    output logic o_terminate_enable_bit,
    output logic o_abort_operation,
    output logic o_clear_write_enable_latch,
    output logic o_reset_volatile,
    output logic o_reset_protection,
    output logic o_clear_error_flag,
    output logic o_invalidate_buffer,
    output logic o_clear_auto_deep_sleep_enable_bit,
    output logic o_ultra_deep_power_down_mode,
    output logic [1:0] o_bus_width,
    output logic o_dtr,
    output logic o_reset_busy,
    output logic o_output_allowed
);

    if (RECOVERY_CYCLES < 9 || RECOVERY_CYCLES > 65535) begin
        $error("RECOVERY_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: bits counted per falling edge of the serial clock
    function automatic logic [15:0] shift_in(input logic [15:0] cap,
                                             input logic [15:0] data,
                                             input logic [4:0] n);
        logic [15:0] r;
        r = cap;
        unique case (n)
            5'h01: r = {cap[14:0], data[0]};
            5'h02: r = {cap[13:0], data[1:0]};
            5'h04: r = {cap[11:0], data[3:0]};
            5'h08: r = {cap[7:0], data[7:0]};
            default: r = data;
        endcase
        return r;
    endfunction

    logic [1:0] lk_width_s1_r;
    logic [1:0] lk_width_s2_r;
    logic lk_dtr_s1_r;
    logic lk_dtr_s2_r;
    logic [7:0] lk_rise_r;
    logic lk_fresh_r;
    logic [5:0] lk_bits_r;
    logic [15:0] lk_cap_r;
    logic [4:0] lk_step;
    logic [15:0] lk_data;
    logic [5:0] lk_base;
    logic [15:0] lk_cap_base;

    // Mode is quasi-static between frames; a mode change made while the
    // clock is stopped takes effect after two falling serial clock edges
    always_ff @(negedge i_sck) begin
        lk_width_s1_r <= o_bus_width;
        lk_width_s2_r <= lk_width_s1_r;
        lk_dtr_s1_r <= o_dtr;
        lk_dtr_s2_r <= lk_dtr_s1_r;
    end

    always_ff @(posedge i_sck) begin
        lk_rise_r <= i_io;
    end

    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            lk_fresh_r <= 1'h1;
        end else begin
            lk_fresh_r <= 1'h0;
        end
    end

    always_comb begin
        lk_step = 5'h01;
        lk_data = {8'h00, lk_rise_r};
        unique case (lk_width_s2_r)
            BUS_QUAD: lk_step = 5'h04;
            BUS_OCTAL: lk_step = 5'h08;
            default: lk_step = 5'h01;
        endcase
        if (lk_dtr_s2_r && lk_width_s2_r != BUS_SPI) begin
            lk_step = {lk_step[3:0], 1'h0};
            if (lk_width_s2_r == BUS_OCTAL) begin
                lk_data = {lk_rise_r, i_io};
            end else begin
                lk_data = {8'h00, lk_rise_r[3:0], i_io[3:0]};
            end
        end
        lk_base = lk_fresh_r ? 6'h00 : lk_bits_r;
        lk_cap_base = lk_fresh_r ? 16'h0000 : lk_cap_r;
    end

    // Results hold after the frame so the core reads them at release
    always_ff @(negedge i_sck) begin
        if (lk_base > BIT_COUNT_MAX - 6'(lk_step)) begin
            lk_bits_r <= BIT_COUNT_MAX;
        end else begin
            lk_bits_r <= lk_base + 6'(lk_step);
        end
        if (lk_base < CAPTURE_BITS) begin
            lk_cap_r <= shift_in(lk_cap_base, lk_data, lk_step);
        end else begin
            lk_cap_r <= lk_cap_base;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: pin synchronisers and frame edges
    typedef enum {ST_IDLE, ST_RECOVERY} state_type;
    logic [2:0] cs_sync_r;
    logic [1:0] si_sync_r;
    logic [2:0] sck_sync_r;
    logic clk_seen_r;
    logic cs_rise;
    logic cs_fall;
    logic sck_edge;
    logic cmd_frame;
    logic [7:0] opcode;
    logic [7:0] confirm;
    logic whole;
    logic [5:0] bits;
    state_type state_r;
    logic [15:0] rec_cnt_r;
    logic armed_r;
    logic [3:0] pat_r;
    logic [2:0] pat_cnt_r;
    logic term_fire;
    logic soft_fire;
    logic hw_fire;
    logic auto_fire;
    logic auto_entered_r;

    always_ff @(posedge i_core_clk) begin
        cs_sync_r <= {cs_sync_r[1:0], i_cs_n};
        si_sync_r <= {si_sync_r[0], i_io[0]};
        sck_sync_r <= {sck_sync_r[1:0], i_sck};
    end

    always_comb begin
        cs_rise = cs_sync_r[1] && !cs_sync_r[2];
        cs_fall = !cs_sync_r[1] && cs_sync_r[2];
        sck_edge = sck_sync_r[1] ^ sck_sync_r[2];
        bits = lk_bits_r;
        whole = (bits[2:0] == 3'h0) && (bits != 6'h00);
        opcode = (bits >= CAPTURE_BITS) ? lk_cap_r[15:8] : lk_cap_r[7:0];
        confirm = lk_cap_r[7:0];
        cmd_frame = cs_rise && (clk_seen_r || sck_edge) && whole
            && state_r == ST_IDLE && !o_ultra_deep_power_down_mode;
        term_fire = cmd_frame && opcode == OP_TERMINATE
            && bits >= CAPTURE_BITS && confirm == TERMINATE_CONFIRM
            && o_terminate_enable_bit;
        soft_fire = cmd_frame && opcode == OP_RESET && armed_r;
        hw_fire = cs_rise && !clk_seen_r && !sck_edge
            && pat_cnt_r == HW_PATTERN_LEN - 3'h1
            && {pat_r[2:0], si_sync_r[1]} == HW_PATTERN;
        auto_fire = i_program_erase_done && i_auto_deep_sleep_enable_bit
            && !o_ultra_deep_power_down_mode;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            clk_seen_r <= 1'h0;
        end else if (!cs_sync_r[1] && sck_edge) begin
            clk_seen_r <= 1'h1;
        end else if (cs_fall || cs_rise) begin
            clk_seen_r <= 1'h0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_output_allowed <= 1'h0;
        end else begin
            o_output_allowed <= !cs_sync_r[1]
                && (clk_seen_r || sck_edge);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clockless reset pattern
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            pat_r <= 4'h0;
            pat_cnt_r <= 3'h0;
        end else if (cs_rise) begin
            if (clk_seen_r || sck_edge || hw_fire) begin
                pat_r <= 4'h0;
                pat_cnt_r <= 3'h0;
            end else begin
                pat_r <= {pat_r[2:0], si_sync_r[1]};
                if (pat_cnt_r == HW_PATTERN_LEN - 3'h1) begin
                    pat_cnt_r <= pat_cnt_r;
                end else begin
                    pat_cnt_r <= pat_cnt_r + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software reset arming and recovery
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            armed_r <= 1'h0;
        end else if (cmd_frame) begin
            armed_r <= (opcode == OP_RESET_ENABLE);
        end else if (hw_fire) begin
            armed_r <= 1'h0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state_r <= ST_IDLE;
            rec_cnt_r <= 16'h0000;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (soft_fire) begin
                        state_r <= ST_RECOVERY;
                        rec_cnt_r <= 16'(RECOVERY_CYCLES - 1);
                    end
                end
                ST_RECOVERY: begin
                    if (rec_cnt_r == 16'h0000) begin
                        state_r <= ST_IDLE;
                    end else begin
                        rec_cnt_r <= rec_cnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    assign o_reset_busy = (state_r == ST_RECOVERY);

    ////////////////////////////////////////////////////////////////////////
    // Mode, enable bit and deep sleep state
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_bus_width <= BUS_WIDTH_RESET;
            o_dtr <= DTR_RESET;
        end else if (soft_fire || hw_fire) begin
            o_bus_width <= BUS_SPI;
            o_dtr <= 1'h0;
        end else if (i_mode_load) begin
            o_bus_width <= i_mode_width;
            o_dtr <= i_mode_dtr;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_terminate_enable_bit <= TERMINATE_ENABLE_BIT_RESET;
        end else if (soft_fire || hw_fire) begin
            o_terminate_enable_bit <= TERMINATE_ENABLE_BIT_RESET;
        end else if (i_status2_write) begin
            o_terminate_enable_bit <= i_status2_terminate_enable;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_ultra_deep_power_down_mode <= 1'h0;
            auto_entered_r <= 1'h0;
        end else if (hw_fire) begin
            o_ultra_deep_power_down_mode <= 1'h0;
            auto_entered_r <= 1'h0;
        end else if (auto_fire) begin
            o_ultra_deep_power_down_mode <= 1'h1;
            auto_entered_r <= 1'h1;
        end else if (i_ultra_deep_power_down_mode_enter) begin
            o_ultra_deep_power_down_mode <= 1'h1;
            auto_entered_r <= 1'h0;
        end else if (i_ultra_deep_power_down_mode_exit) begin
            o_ultra_deep_power_down_mode <= 1'h0;
            auto_entered_r <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Action pulses, one core cycle each
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_abort_operation <= 1'h0;
            o_clear_write_enable_latch <= 1'h0;
            o_reset_volatile <= 1'h0;
            o_reset_protection <= 1'h0;
            o_clear_error_flag <= 1'h0;
            o_invalidate_buffer <= 1'h0;
            o_clear_auto_deep_sleep_enable_bit <= 1'h0;
        end else begin
            o_abort_operation <= term_fire || soft_fire || hw_fire;
            o_clear_write_enable_latch <= soft_fire || hw_fire
                || (term_fire && !i_sequential_programming);
            o_reset_volatile <= soft_fire || hw_fire;
            o_reset_protection <= soft_fire || hw_fire;
            o_clear_error_flag <= soft_fire
                || (hw_fire && !(o_ultra_deep_power_down_mode
                && auto_entered_r));
            o_invalidate_buffer <= hw_fire
                && o_ultra_deep_power_down_mode;
            o_clear_auto_deep_sleep_enable_bit <= auto_fire
                || i_ultra_deep_power_down_mode_enter;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    localparam int TERM_LAT = TERMINATE_LATENCY_CYC;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_soft_accept;
        soft_fire;
    endsequence
    sequence s_recovering;
        o_reset_busy [*8];
    endsequence
    AST_TERM_ABORT: assert property (term_fire |-> ##[1:TERM_LAT]
        o_abort_operation) else $error("terminate did not abort");
    AST_TERM_NEEDS_ENABLE: assert property (cmd_frame
        && opcode == OP_TERMINATE && !o_terminate_enable_bit
        |=> !o_abort_operation) else $error("terminate ran while disabled");
    AST_WHOLE_BYTE: assert property (cs_rise && clk_seen_r
        && bits[2:0] != 3'h0 |=> !o_abort_operation && !o_reset_volatile)
        else $error("action on partial byte");
    AST_TERM_KEEPS_ENABLE: assert property (term_fire && !soft_fire
        |=> $stable(o_terminate_enable_bit) && o_clear_write_enable_latch
        == !$past(i_sequential_programming))
        else $error("terminate side effects wrong");
    AST_DISARM: assert property (cmd_frame
        && opcode != OP_RESET_ENABLE |=> !armed_r)
        else $error("reset pair not disarmed");
    AST_RECOVERY: assert property (s_soft_accept |=> s_recovering)
        else $error("recovery interval too short");
    AST_RECOVERY_REFUSE: assert property (o_reset_busy && !hw_fire
        |=> !o_abort_operation) else $error("instruction taken in recovery");
    AST_SOFT_SPI: assert property (s_soft_accept |=> o_bus_width
        == BUS_SPI && !o_dtr && o_reset_volatile && o_abort_operation)
        else $error("soft reset left mode or state");
    AST_SCK_ABORT: assert property (cs_rise && clk_seen_r
        |=> pat_cnt_r == 3'h0) else $error("pattern kept after clocking");
    AST_HW_RESET: assert property (hw_fire |=> o_reset_volatile
        && !o_ultra_deep_power_down_mode && o_bus_width == BUS_SPI)
        else $error("pattern reset incomplete");
    AST_EPE_KEEP: assert property (hw_fire && auto_entered_r
        && o_ultra_deep_power_down_mode |=> !o_clear_error_flag
        && o_invalidate_buffer) else $error("error flag lost");
    AST_AUTO_SLEEP: assert property (auto_fire && !hw_fire
        |=> o_ultra_deep_power_down_mode
        && o_clear_auto_deep_sleep_enable_bit)
        else $error("auto deep sleep missed");

endmodule
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output var logic o_sck,
    output var logic o_cs_n,
    output var logic [7:0] o_io,
    output var logic o_pat
);
    // A rising chip select presets the link's frame flag, which has no reset
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b0;
        o_io = 8'h00;
        o_pat = 1'b0;
        #1 o_cs_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    // Clocked frame, MSB first, ln lanes per edge, dtr uses both edges
    task automatic frame(input logic [31:0] d, input int n,
                         input int ln, input logic dtr);
        int k;
        k = 0;
        o_cs_n = 1'b0;
        while (k < n) begin
            o_io = 8'(d >> (32 - ln));
            d = d << ln;
            k += ln;
            #3.75 o_sck = ~o_sck;
            #3.75;
            if (!dtr) begin
                #3.75 o_sck = 1'b0;
                #3.75;
            end
        end
        // Last edge must be falling or the final byte is never assembled
        if (o_sck) begin
            #3.75 o_sck = 1'b0;
            #3.75;
        end
        o_cs_n = 1'b1;
        #5 o_io = ~o_io;
        #55;
    endtask
    // Pattern step: SI set as chip select falls, clock left still
    task automatic step(input logic b);
        o_cs_n = 1'b0;
        o_io[0] = b;
        o_pat = 1'b1;
        #40 o_pat = 1'b0;
        o_cs_n = 1'b1;
        // SI held past the synchroniser depth before it is let go
        #40 o_io = ~o_io;
        #30;
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flash_rst_pkg::*;
    localparam int RECOVERY = 80;
    typedef struct {
        logic [31:0] d;
        int n;
        logic terminate_enable_bit;
        logic seq;
        logic [7:0] exp;
    } row_type;
    logic i_core_clk, i_reset_n = 1'b0, i_status2_write = 1'b0;
    logic i_status2_terminate_enable = 1'b0, i_mode_load = 1'b0;
    logic i_sequential_programming = 1'b0, i_mode_dtr = 1'b0;
    logic i_auto_deep_sleep_enable_bit = 1'b0, i_ultra_deep_power_down_mode_exit = 1'b0;
    logic i_program_erase_done = 1'b0, i_ultra_deep_power_down_mode_enter = 1'b0;
    logic [1:0] i_mode_width = 2'h0;
    wire logic i_sck, i_cs_n, pat_low;
    wire logic [7:0] i_io;
    logic o_terminate_enable_bit, o_abort_operation, o_reset_volatile;
    logic o_clear_write_enable_latch, o_reset_protection, o_clear_error_flag;
    logic o_invalidate_buffer, o_clear_auto_deep_sleep_enable_bit, o_dtr;
    logic o_ultra_deep_power_down_mode, o_reset_busy, o_output_allowed;
    logic [1:0] o_bus_width;
    logic [6:0] pul;
    logic [7:0] g;
    logic seen_drive = 1'b0, seen_clocked = 1'b0;
    int cnt [7] = '{default: 0};
    int snap [7] = '{default: 0};
    int failures = 0;
    int checks_done = 0;
    row_type rows [8] = '{
        '{32'hF0D0_0000, 16, 1'b1, 1'b0, 8'h60},
        '{32'hF0D0_0000, 16, 1'b1, 1'b1, 8'h40},
        '{32'hF0D0_0000, 16, 1'b0, 1'b0, 8'h00},
        '{32'hF0D0_A500, 24, 1'b1, 1'b0, 8'h60},
        '{32'hF000_0000, 8, 1'b1, 1'b0, 8'h00},
        '{32'hF0D0_0000, 19, 1'b1, 1'b0, 8'h00},
        '{32'hF0C0_0000, 16, 1'b1, 1'b0, 8'h00},
        '{32'hF000_D000, 24, 1'b1, 1'b0, 8'h00}
    };

    flash_terminate_and_reset_control #(.RECOVERY_CYCLES(RECOVERY))
    i_flash_terminate_and_reset_control (
        .i_core_clk, .i_reset_n, .i_sck, .i_cs_n, .i_io, .i_status2_write,
        .i_status2_terminate_enable, .i_sequential_programming, .i_mode_load,
        .i_mode_width, .i_mode_dtr, .i_auto_deep_sleep_enable_bit,
        .i_program_erase_done, .i_ultra_deep_power_down_mode_enter, .i_ultra_deep_power_down_mode_exit,
        .o_terminate_enable_bit, .o_abort_operation,
        .o_clear_write_enable_latch, .o_reset_volatile, .o_reset_protection,
        .o_clear_error_flag, .o_invalidate_buffer,
        .o_clear_auto_deep_sleep_enable_bit, .o_ultra_deep_power_down_mode,
        .o_bus_width, .o_dtr, .o_reset_busy, .o_output_allowed
    );
    host_model i_host_model (
        .o_sck(i_sck), .o_cs_n(i_cs_n), .o_io(i_io), .o_pat(pat_low)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    ////////////////////////////////////////////////////////////
    // Pulses are counted, so their exact cycle after the sync need not matter
    assign pul = {o_abort_operation, o_clear_write_enable_latch,
        o_reset_volatile, o_reset_protection, o_clear_error_flag,
        o_invalidate_buffer, o_clear_auto_deep_sleep_enable_bit};
    always @(posedge i_core_clk) begin
        for (int j = 0; j < 7; j++) begin
            cnt[j] <= cnt[j] + int'(pul[j] === 1'b1);
        end
        if (pat_low && o_output_allowed === 1'b1) begin
            seen_drive <= 1'b1;
        end
        if (!pat_low && o_output_allowed === 1'b1) begin
            seen_clocked <= 1'b1;
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bit 7 flags a pulse seen twice
    task automatic settle();
        repeat (12) @(posedge i_core_clk);
        g = 8'h00;
        for (int j = 0; j < 7; j++) begin
            g[j] = (cnt[j] - snap[j]) == 1;
            g[7] = g[7] | ((cnt[j] - snap[j]) > 1);
        end
        snap = cnt;
    endtask
    task automatic set_terminate_enable_bit(input logic b);
        @(posedge i_core_clk);
        i_status2_write <= 1'b1;
        i_status2_terminate_enable <= b;
        @(posedge i_core_clk);
        i_status2_write <= 1'b0;
    endtask
    task automatic set_mode(input logic [1:0] w, input logic r);
        @(posedge i_core_clk);
        i_mode_load <= 1'b1;
        i_mode_width <= w;
        i_mode_dtr <= r;
        @(posedge i_core_clk);
        i_mode_load <= 1'b0;
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic spi(input logic [7:0] op);
        i_host_model.frame({op, 24'h0}, 8, 1, 1'b0);
    endtask
    // A clocked frame first, so stale pattern progress cannot help
    task automatic jedec();
        spi(8'h00);
        for (int i = 3; i >= 0; i--) begin
            i_host_model.step(HW_PATTERN[i]);
        end
        settle();
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (o_reset_busy !== 1'b0 && k < 200) begin
            @(posedge i_core_clk);
            k++;
        end
        check({7'h0, o_reset_busy}, 8'h00);
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        check({6'h0, o_bus_width}, {6'h0, BUS_WIDTH_RESET});
        check({o_terminate_enable_bit, o_reset_busy, o_dtr,
            o_ultra_deep_power_down_mode, 4'h0}, 8'h00);
        note("reset");
        foreach (rows[r]) begin
            set_terminate_enable_bit(rows[r].terminate_enable_bit);
            i_sequential_programming <= rows[r].seq;
            i_host_model.frame(rows[r].d, rows[r].n, 1, 1'b0);
            settle();
            check(g, rows[r].exp);
            check({7'h0, o_terminate_enable_bit}, 8'(rows[r].terminate_enable_bit));
        end
        i_sequential_programming <= 1'b0;
        note("terminate table");
        wait_idle();
        spi(8'h66);
        spi(8'h99);
        settle();
        check(g, 8'h7C);
        check({o_reset_busy, 7'h0}, 8'h80);
        spi(8'h66);
        spi(8'h99);
        settle();
        check(g, 8'h00);
        wait_idle();
        spi(8'h66);
        spi(8'h05);
        spi(8'h99);
        settle();
        check(g, 8'h00);
        note("soft reset");
        set_mode(BUS_QUAD, 1'b1);
        check({5'h0, o_dtr, o_bus_width}, {5'h0, 1'b1, BUS_QUAD});
        // Dummy frame gives the link side two falling edges to take the mode
        i_host_model.frame(32'h0, 16, 4, 1'b1);
        i_host_model.frame(32'h6600_0000, 8, 4, 1'b1);
        i_host_model.frame(32'h9900_0000, 8, 4, 1'b1);
        settle();
        check(g, 8'h7C);
        check({5'h0, o_dtr, o_bus_width}, {6'h0, BUS_SPI});
        wait_idle();
        set_terminate_enable_bit(1'b1);
        set_mode(BUS_OCTAL, 1'b0);
        i_host_model.frame(32'h0, 16, 8, 1'b0);
        i_host_model.frame(32'hF0D0_0000, 16, 8, 1'b0);
        settle();
        check(g, 8'h60);
        check({7'h0, seen_clocked}, 8'h01);
        note("wide modes");
        i_host_model.step(1'b0);
        i_host_model.step(1'b1);
        i_host_model.frame(32'h0, 16, 8, 1'b0);
        i_host_model.step(1'b0);
        i_host_model.step(1'b1);
        settle();
        check(g, 8'h00);
        jedec();
        check(g, 8'h7C);
        check({5'h0, o_dtr, o_bus_width}, {6'h0, BUS_SPI});
        check({7'h0, seen_drive}, 8'h00);
        @(posedge i_core_clk);
        i_auto_deep_sleep_enable_bit <= 1'b1;
        i_program_erase_done <= 1'b1;
        @(posedge i_core_clk);
        i_program_erase_done <= 1'b0;
        settle();
        i_auto_deep_sleep_enable_bit <= 1'b0;
        check(g, 8'h01);
        check({7'h0, o_ultra_deep_power_down_mode}, 8'h01);
        jedec();
        check(g, 8'h7A);
        check({7'h0, o_ultra_deep_power_down_mode}, 8'h00);
        @(posedge i_core_clk);
        i_ultra_deep_power_down_mode_enter <= 1'b1;
        @(posedge i_core_clk);
        i_ultra_deep_power_down_mode_enter <= 1'b0;
        jedec();
        check(g, 8'h7F);
        note("pattern");
        set_terminate_enable_bit(1'b1);
        set_mode(BUS_OCTAL, 1'b1);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        check({4'h0, o_terminate_enable_bit, o_dtr, o_bus_width},
            {4'h0, TERMINATE_ENABLE_BIT_RESET, DTR_RESET, BUS_WIDTH_RESET});
        note("mid reset");
        wrap_up();
    end
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
